// File: src/clksrc_consts.svh
`ifndef CLKSRC_CONSTS_SVH
`define CLKSRC_CONSTS_SVH

// Register offsets
`define CS_ADDR_CTRL_ONE      8'h00
`define CS_ADDR_CTRL_TWO      8'h01
`define CS_ADDR_PERIOD_ADJ    8'h02
`define CS_ADDR_STATUS        8'h03

// Control one fields
`define CS_SRC_HI             7
`define CS_SRC_LO             6
`define CS_REFERENCE_DIVIDER_HI            5
`define CS_REFERENCE_DIVIDER_LO            3
`define CS_INT_CHOOSE         2
`define CS_INT_OUT_ON         1
`define CS_INT_KEEP_STOP      0

// Control two fields
`define CS_BUS_DIVIDER_HI            7
`define CS_BUS_DIVIDER_LO            6
`define CS_OSC_HIGH_BAND      5
`define CS_OSC_HIGH_GAIN      4
`define CS_LOOP_OFF_BYPASS    3
`define CS_EXT_KIND           2
`define CS_EXT_OUT_ON         1
`define CS_EXT_KEEP_STOP      0

// Status fields
`define CS_ST_INT_REF         4
`define CS_ST_MODE_HI         3
`define CS_ST_MODE_LO         2
`define CS_ST_FINE            0

// Reset values and source select codes
`define CS_CTRL_ONE_RST       8'h04
`define CS_CTRL_TWO_RST       8'h40
`define CS_PERIOD_ADJ_RST     8'h80
`define CS_FINE_RST           1'b0
`define CS_SRC_RSVD_CODE      2'h3
`define CS_SRC_LOOP_CODE      2'h0

// Loop multiplication factor
`define CS_LOOP_RATIO         16'h0400

`endif

// File: src/clksrc_pkg.sv
package clksrc_pkg;

    typedef enum logic [1:0] {
        CS_SRC_LOOP,
        CS_SRC_INT,
        CS_SRC_EXT,
        CS_SRC_RSVD
    } clksrc_source_type;

    typedef enum logic [2:0] {
        CS_MODE_LOOP_ENGAGED_INTERNAL,
        CS_MODE_LOOP_ENGAGED_EXTERNAL,
        CS_MODE_LOOP_BYPASSED_INTERNAL,
        CS_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER,
        CS_MODE_LOOP_BYPASSED_EXTERNAL,
        CS_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER,
        CS_MODE_STOP
    } clksrc_mode_type;

endpackage

// File: src/clksrc_pow2_div.sv
`timescale 1ns/10ps

module clksrc_pow2_div #(
    parameter int SHIFT_W = 3
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               tickIn,
    input  wire logic [SHIFT_W-1:0] shift,
    output logic                    tickOut
);

    localparam int CW = (1 << SHIFT_W) - 1;

    logic [CW-1:0] count;
    logic [CW-1:0] mask;

    if (SHIFT_W < 1 || SHIFT_W > 4) begin : g_chk
        $error("clksrc_pow2_div: SHIFT_W must be 1 to 4");
    end

    // Low bits all ones marks every 2**shift input ticks
    assign mask = ~({CW{1'b1}} << shift);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (tickIn) begin
            count <= count + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tickOut <= 1'b0;
        end else begin
            tickOut <= tickIn && ((count & mask) == mask);
        end
    end

endmodule

// File: src/clksrc_sync.sv
`timescale 1ns/10ps

module clksrc_sync #(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] dataIn,
    output logic      [WIDTH-1:0] dataOut
);

    logic [WIDTH-1:0] stageOne;

    if (WIDTH < 1) begin : g_chk
        $error("clksrc_sync: WIDTH must be at least 1");
    end

    // Models the crossing into the clock switching domain
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stageOne <= RST_VALUE;
            dataOut  <= RST_VALUE;
        end else begin
            stageOne <= dataIn;
            dataOut  <= stageOne;
        end
    end

endmodule

// File: src/clksrc_regs.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "clksrc_consts.svh"

//Behaviour
//- Source select 00 loop, 01 internal, 10 external reference clock.
//- Writing reserved select 11 stores and acts as 00.
//- Reference divider divides loop reference by two to the field value.
//- Reference divider resets to 000, undivided.
//- Internal-choose bit picks internal (1) or external (0) loop reference.
//- Internal output-on bit gates the internal reference output.
//- Internal keep-in-stop holds internal reference in stop if needed.
//- Bus divider divides selected source by 1, 2, 4 or 8.
//- Bus divider resets to 01, divide by two.
//- Band bit selects oscillator high or low frequency band.
//- Gain bit selects oscillator high gain or low power.
//- Loop-off bit stops loop in bypass unless debug is active.
//- External kind bit requests crystal oscillator or clock input.
//- External output-on bit gates the external reference output.
//- External keep-in-stop holds external reference in stop if needed.
//- Eight-bit adjust lengthens internal period as its value grows.
//- Fine adjust bit adds the smallest period step.
//- Mode status follows select only after synchronisation.
//- Engaged loop locks to 1024 times divided reference.
module clksrc_regs
    import clksrc_pkg::*;
#(
    parameter int INT_BASE_CYCLES = 64,
    parameter int PERIOD_W        = 10
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       stopMode,
    input  wire logic       backgroundDebugActive,
    input  wire logic       externalReferenceIn,
    input  wire logic       loopOutputIn,
    output logic            systemClockOut,
    output logic            internalReferenceOut,
    output logic            externalReferenceOut,
    output logic            loopReferenceTick,
    output logic            loopEnable,
    output logic            loopTrimUp,
    output logic            loopTrimDown,
    output logic            oscillatorHighBand,
    output logic            oscillatorHighGain,
    output logic            externalSourceKind,
    output logic            externalOscillatorEnable
);

    localparam logic [PERIOD_W-1:0] BASE = PERIOD_W'(INT_BASE_CYCLES);

    logic [7:0]            clockControlOne;
    logic [7:0]            clockControlTwo;
    logic [7:0]            referencePeriodAdjust;
    logic                  finePeriodAdjust;
    logic [2:0]            syncSelect;
    clksrc_source_type     currentSource;
    logic                  currentIntChoose;
    clksrc_mode_type       mode;
    logic                  priorUsedInt;
    logic                  priorUsedExt;
    logic                  intRun;
    logic                  extRun;
    logic                  keepInt;
    logic                  keepExt;
    logic [PERIOD_W-1:0]   intPeriod;
    logic [PERIOD_W-1:0]   periodCount;
    logic                  intTick;
    logic                  extTick;
    logic                  refSrcTick;
    logic                  selTick;
    logic [15:0]           loopCount;
    logic                  wrOne;
    logic                  wrTwo;
    logic                  wrAdj;
    logic                  wrStat;

    if (INT_BASE_CYCLES < 2 ||
        INT_BASE_CYCLES + 511 >= (1 << PERIOD_W)) begin : g_chk
        $error("clksrc_regs: INT_BASE_CYCLES does not fit PERIOD_W");
    end

    ////////////////////////////////////////////////////////////////////
    // Register port

    assign wrOne  = regWrite && (regAddr == `CS_ADDR_CTRL_ONE);
    assign wrTwo  = regWrite && (regAddr == `CS_ADDR_CTRL_TWO);
    assign wrAdj  = regWrite && (regAddr == `CS_ADDR_PERIOD_ADJ);
    assign wrStat = regWrite && (regAddr == `CS_ADDR_STATUS);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clockControlOne <= `CS_CTRL_ONE_RST;
        end else if (wrOne) begin
            clockControlOne <= regWrData;
            if (regWrData[`CS_SRC_HI:`CS_SRC_LO] == `CS_SRC_RSVD_CODE) begin
                // Reserved code folds to loop output
                clockControlOne[`CS_SRC_HI:`CS_SRC_LO] <=
                    `CS_SRC_LOOP_CODE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clockControlTwo <= `CS_CTRL_TWO_RST;
        end else if (wrTwo) begin
            clockControlTwo <= regWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            referencePeriodAdjust <= `CS_PERIOD_ADJ_RST;
            finePeriodAdjust      <= `CS_FINE_RST;
        end else begin
            if (wrAdj) begin
                referencePeriodAdjust <= regWrData;
            end
            if (wrStat) begin
                finePeriodAdjust <= regWrData[`CS_ST_FINE];
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (!regRead) begin
            regRdData <= 8'h00;
        end else if (regAddr == `CS_ADDR_CTRL_ONE) begin
            regRdData <= clockControlOne;
        end else if (regAddr == `CS_ADDR_CTRL_TWO) begin
            regRdData <= clockControlTwo;
        end else if (regAddr == `CS_ADDR_PERIOD_ADJ) begin
            regRdData <= referencePeriodAdjust;
        end else if (regAddr == `CS_ADDR_STATUS) begin
            regRdData <= {3'h0, currentIntChoose, syncSelect[1:0],
                          1'b0, finePeriodAdjust};
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selection crossing and mode

    clksrc_sync #(
        .WIDTH     (3),
        .RST_VALUE (3'h4)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .dataIn   ({clockControlOne[`CS_INT_CHOOSE],
                    clockControlOne[`CS_SRC_HI:`CS_SRC_LO]}),
        .dataOut  (syncSelect)
    );

    assign currentSource    = clksrc_source_type'(syncSelect[1:0]);
    assign currentIntChoose = syncSelect[2];

    // Unlisted select/choose pairs follow the select field
    always_comb begin
        mode = CS_MODE_LOOP_ENGAGED_INTERNAL;
        if (stopMode) begin
            mode = CS_MODE_STOP;
        end else begin
            case (currentSource)
                CS_SRC_INT: begin
                    if (clockControlTwo[`CS_LOOP_OFF_BYPASS] &&
                        !backgroundDebugActive) begin
                        mode = CS_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER;
                    end else begin
                        mode = CS_MODE_LOOP_BYPASSED_INTERNAL;
                    end
                end
                CS_SRC_EXT: begin
                    if (clockControlTwo[`CS_LOOP_OFF_BYPASS] &&
                        !backgroundDebugActive) begin
                        mode = CS_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER;
                    end else begin
                        mode = CS_MODE_LOOP_BYPASSED_EXTERNAL;
                    end
                end
                default: begin
                    if (currentIntChoose) begin
                        mode = CS_MODE_LOOP_ENGAGED_INTERNAL;
                    end else begin
                        mode = CS_MODE_LOOP_ENGAGED_EXTERNAL;
                    end
                end
            endcase
        end
    end

    // Loop off in stop and in low power bypass
    assign loopEnable = (mode != CS_MODE_STOP) &&
        (mode != CS_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER) &&
        (mode != CS_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER);

    ////////////////////////////////////////////////////////////////////
    // Stop entry

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            priorUsedInt <= 1'b1;
            priorUsedExt <= 1'b0;
        end else begin
            if (!stopMode) begin
                // Last run mode is what stop entry looks back at
                priorUsedInt <= currentSource == CS_SRC_INT ||
                    (currentSource != CS_SRC_EXT && currentIntChoose);
                priorUsedExt <= currentSource == CS_SRC_EXT ||
                    (currentSource != CS_SRC_INT && !currentIntChoose);
            end
        end
    end

    assign keepInt = clockControlOne[`CS_INT_KEEP_STOP] &&
        (clockControlOne[`CS_INT_OUT_ON] || priorUsedInt);
    assign keepExt = clockControlTwo[`CS_EXT_KEEP_STOP] &&
        (clockControlTwo[`CS_EXT_OUT_ON] || priorUsedExt);
    assign intRun = stopMode ? keepInt : 1'b1;
    assign extRun = stopMode ? keepExt :
        (clockControlTwo[`CS_EXT_OUT_ON] || priorUsedExt);

    ////////////////////////////////////////////////////////////////////
    // Internal reference oscillator and references

    // Nine-bit adjust, fine bit as the least weight
    assign intPeriod = BASE + PERIOD_W'({referencePeriodAdjust,
                                          finePeriodAdjust});

    always_ff @(posedge core_clk) begin
        if (sys_rst || !intRun) begin
            periodCount <= '0;
        end else if (periodCount >= intPeriod - PERIOD_W'(1)) begin
            periodCount <= '0;
        end else begin
            periodCount <= periodCount + PERIOD_W'(1);
        end
    end

    assign intTick = intRun && (periodCount >= intPeriod - PERIOD_W'(1));
    assign extTick = externalReferenceIn && extRun;

    assign internalReferenceOut = intTick &&
        clockControlOne[`CS_INT_OUT_ON];
    assign externalReferenceOut = extTick &&
        clockControlTwo[`CS_EXT_OUT_ON];

    assign oscillatorHighBand       =
        clockControlTwo[`CS_OSC_HIGH_BAND];
    assign oscillatorHighGain       =
        clockControlTwo[`CS_OSC_HIGH_GAIN];
    assign externalSourceKind       = clockControlTwo[`CS_EXT_KIND];
    assign externalOscillatorEnable = extRun;

    ////////////////////////////////////////////////////////////////////
    // Dividers

    assign refSrcTick = currentIntChoose ? intTick : extTick;

    clksrc_pow2_div #(
        .SHIFT_W (3)
    ) u_ref_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tickIn   (refSrcTick && loopEnable),
        .shift    (clockControlOne[`CS_REFERENCE_DIVIDER_HI:`CS_REFERENCE_DIVIDER_LO]),
        .tickOut  (loopReferenceTick)
    );

    always_comb begin
        selTick = 1'b0;
        case (currentSource)
            CS_SRC_INT: selTick = intTick;
            CS_SRC_EXT: selTick = extTick;
            default:    selTick = loopOutputIn && loopEnable;
        endcase
    end

    clksrc_pow2_div #(
        .SHIFT_W (2)
    ) u_bus_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tickIn   (selTick && !stopMode),
        .shift    (clockControlTwo[`CS_BUS_DIVIDER_HI:`CS_BUS_DIVIDER_LO]),
        .tickOut  (systemClockOut)
    );

    ////////////////////////////////////////////////////////////////////
    // Loop frequency comparison

    // Saturating count, so a dead reference cannot wrap into a lock
    always_ff @(posedge core_clk) begin
        if (sys_rst || !loopEnable || loopReferenceTick) begin
            loopCount <= {15'h0000, loopOutputIn && loopEnable};
        end else if (loopOutputIn && loopCount != 16'hFFFF) begin
            loopCount <= loopCount + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !loopEnable) begin
            loopTrimUp   <= 1'b0;
            loopTrimDown <= 1'b0;
        end else if (loopReferenceTick) begin
            loopTrimUp   <= loopCount < `CS_LOOP_RATIO;
            loopTrimDown <= loopCount > `CS_LOOP_RATIO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [PERIOD_W:0] gapCount;
    logic              gapSeen;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !intRun || wrAdj || wrStat) begin
            gapCount <= '0;
            gapSeen  <= 1'b0;
        end else if (intTick) begin
            gapCount <= (PERIOD_W+1)'(1);
            gapSeen  <= 1'b1;
        end else begin
            gapCount <= gapCount + (PERIOD_W+1)'(1);
        end
    end

    property p_rsvd_fold;
        wrOne && regWrData[7:6] == 2'h3 |=> clockControlOne[7:6] == 2'h0;
    endproperty
    a_rsvd_fold: assert property (p_rsvd_fold)
        else $error("reserved select not folded to loop");

    property p_status_lag;
        wrOne && regWrData[7:6] == 2'h1 && syncSelect[1:0] != 2'h1 |=>
            syncSelect[1:0] != 2'h1 ##2 syncSelect[1:0] == 2'h1;
    endproperty
    a_status_lag: assert property (p_status_lag)
        else $error("mode status timing wrong");

    property p_reset_fields;
        $past(sys_rst) |-> clockControlOne[5:3] == 3'h0 &&
            clockControlTwo[7:6] == 2'h1;
    endproperty
    a_reset_fields: assert property (p_reset_fields)
        else $error("divider fields not at reset value");

    property p_reference_divider_pass;
        clockControlOne[5:3] == 3'h0 && refSrcTick && loopEnable |=>
            loopReferenceTick;
    endproperty
    a_reference_divider_pass: assert property (p_reference_divider_pass)
        else $error("undivided reference tick missing");

    property p_int_stop_off;
        stopMode && !clockControlOne[0] |-> !intTick && !internalReferenceOut;
    endproperty
    a_int_stop_off: assert property (p_int_stop_off)
        else $error("internal reference runs in stop");

    property p_ext_stop_off;
        stopMode && !clockControlTwo[0] |-> !externalOscillatorEnable;
    endproperty
    a_ext_stop_off: assert property (p_ext_stop_off)
        else $error("external reference runs in stop");

    property p_low_power;
        clockControlTwo[3] && !backgroundDebugActive &&
            (syncSelect[1:0] == 2'h1 || syncSelect[1:0] == 2'h2) |->
            !loopEnable ##1 !loopReferenceTick;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("loop not off in low power bypass");

    property p_int_period;
        intTick && gapSeen |-> gapCount == (PERIOD_W+1)'(intPeriod);
    endproperty
    a_int_period: assert property (p_int_period)
        else $error("internal reference period wrong");

    property p_lock_dir;
        loopEnable && loopReferenceTick && loopCount < 16'h0400 |=>
            loopTrimUp && !loopTrimDown;
    endproperty
    a_lock_dir: assert property (p_lock_dir)
        else $error("loop trim direction wrong");

    property p_no_sys_stop;
        stopMode |=> !systemClockOut;
    endproperty
    a_no_sys_stop: assert property (p_no_sys_stop)
        else $error("system clock in stop");

    c_stop_keep: cover property (stopMode && keepInt && intTick);
    c_bypass_ext: cover property (mode == CS_MODE_LOOP_BYPASSED_EXTERNAL
                                  && systemClockOut);
    c_lock: cover property (loopReferenceTick && loopCount == 16'h0400);

endmodule

// File: verification/test_clock_source_control_regs.sv
`timescale 1ns/10ps

module test_clock_source_control_regs;

    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  regAddr   = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrite  = 1'b0;
    logic        regRead   = 1'b0;
    logic        stopMode  = 1'b0;
    logic        dbgOn     = 1'b0;
    logic        extTick   = 1'b0;
    logic        loopTick  = 1'b0;
    logic [7:0]  regRdData;
    logic        sysOut, intOut, extOut, refTick, loopEn;
    logic        trimUp, trimDn, hiBand, hiGain, extKind, oscEn;
    logic [31:0] rng       = 32'h0000001B;
    logic [7:0]  expQ[$];
    logic        rdLast    = 1'b0;
    int          errorCnt  = 0;
    int          samplesChecked = 0;
    int          cyc       = 0;
    int          sysCnt    = 0;
    int          refCnt    = 0;
    int          irCnt     = 0;
    int          erCnt     = 0;

    always #5 core_clk = ~core_clk;

    // Short base period keeps the internal reference fast in simulation
    clksrc_regs #(.INT_BASE_CYCLES(2), .PERIOD_W(10)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .stopMode(stopMode),
        .backgroundDebugActive(dbgOn), .externalReferenceIn(extTick),
        .loopOutputIn(loopTick), .systemClockOut(sysOut),
        .internalReferenceOut(intOut), .externalReferenceOut(extOut),
        .loopReferenceTick(refTick), .loopEnable(loopEn),
        .loopTrimUp(trimUp), .loopTrimDown(trimDn),
        .oscillatorHighBand(hiBand), .oscillatorHighGain(hiGain),
        .externalSourceKind(extKind), .externalOscillatorEnable(oscEn));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters; cleared at negedge so no race with the posedge count
    always @(posedge core_clk) begin
        rdLast <= regRead;
        cyc <= cyc + 1;
        if (sysOut === 1'b1) sysCnt <= sysCnt + 1;
        if (refTick === 1'b1) refCnt <= refCnt + 1;
        if (intOut === 1'b1) irCnt <= irCnt + 1;
        if (extOut === 1'b1) erCnt <= erCnt + 1;
        if (cyc == 30000) begin
            errorCnt++;
            report_and_stop();
        end
    end

    // Read data stands one cycle only, so sample it mid-cycle
    always @(negedge core_clk)
        if (rdLast === 1'b1) chk(regRdData, expQ.pop_front());

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge core_clk);
        regRead <= 1'b0;
    endtask

    task automatic ticks(input bit useLoop, input int n);
        repeat (n) begin
            @(posedge core_clk);
            if (useLoop) loopTick <= 1'b1;
            else extTick <= 1'b1;
            @(posedge core_clk);
            loopTick <= 1'b0;
            extTick <= 1'b0;
            repeat (xs() % 3) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask

    task automatic clr();
        @(negedge core_clk);
        sysCnt = 0;
        refCnt = 0;
        irCnt = 0;
        erCnt = 0;
    endtask

    task automatic ir_edge(output int t);
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (intOut !== 1'b1 && k < 600);
        t = cyc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin : main
        int t0, t1, a;
        logic [7:0] v;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h04);
        rd(8'h01, 8'h40);
        rd(8'h02, 8'h80);
        rd(8'h03, 8'h10);
        rd(8'h20, 8'h00);
        repeat (4) begin
            v = 8'(xs());
            wr(8'h01, v);
            rd(8'h01, v);
            chk({5'h00, hiBand, hiGain, extKind},
                {5'h00, v[5], v[4], v[2]});
        end
        wr(8'h00, 8'hC0);
        rd(8'h00, 8'h00);
        $display("register access done");
        // Windows of 64 ticks make the count independent of divider phase
        for (int s = 0; s < 3; s++)
            for (int b = 0; b < 4; b++) begin
                v = (s == 0) ? 8'h00 : (s == 1) ? 8'h80 : 8'hC0;
                wr(8'h00, v);
                wr(8'h01, {b[1:0], 4'h0, b[0], 1'b0});
                repeat (5) @(posedge core_clk);
                clr();
                ticks(s != 1, 64);
                chk(8'(sysCnt), 8'(64 >> b));
                if (s == 1) chk(8'(erCnt), b[0] ? 8'h40 : 8'h00);
            end
        $display("source and bus divider done");
        for (int r = 0; r < 8; r++) begin
            wr(8'h00, {2'b00, r[2:0], 3'b000});
            repeat (3) @(posedge core_clk);
            clr();
            ticks(1'b0, 128);
            chk(8'(refCnt), 8'(128 >> r));
        end
        $display("reference divider done");
        wr(8'h00, 8'h44);
        for (int k = 0; k < 4; k++) begin
            wr(8'h01, {4'h0, k[0], 3'b000});
            dbgOn <= k[1];
            repeat (5) @(posedge core_clk);
            chk({7'h00, loopEn}, {7'h00, !(k[0] && !k[1])});
        end
        dbgOn <= 1'b0;
        $display("loop low power done");
        // Status lags the write, so the first read still shows bypass
        wr(8'h00, 8'h00);
        rd(8'h03, 8'h14);
        rd(8'h03, 8'h00);
        // Steady loop input makes the count per reference tick the spacing
        loopTick <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            repeat (3) begin
                extTick <= 1'b1;
                @(posedge core_clk);
                extTick <= 1'b0;
                repeat (k ? 1099 : 99) @(posedge core_clk);
            end
            chk({6'h00, trimUp, trimDn}, k ? 8'h01 : 8'h02);
        end
        loopTick <= 1'b0;
        $display("loop lock done");
        wr(8'h00, 8'h06);
        for (int k = 0; k < 2; k++) begin
            a = xs() % 16;
            wr(8'h02, 8'(a));
            wr(8'h03, {7'h00, k[0]});
            rd(8'h03, {7'h08, k[0]});
            ir_edge(t0);
            ir_edge(t0);
            ir_edge(t1);
            chk(8'(t1 - t0), 8'(2 + 2 * a + k));
        end
        $display("period adjust done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, {7'h03, k[0]});
            wr(8'h01, {7'h01, k[0]});
            stopMode <= 1'b1;
            repeat (3) @(posedge core_clk);
            clr();
            repeat (60) @(posedge core_clk);
            chk({7'h00, oscEn}, {7'h00, k[0]});
            chk(8'(irCnt > 0), {7'h00, k[0]});
            stopMode <= 1'b0;
        end
        wr(8'h00, 8'h04);
        clr();
        repeat (60) @(posedge core_clk);
        chk(8'(irCnt), 8'h00);
        $display("stop and output gating done");
        report_and_stop();
    end

endmodule
